// file: core/bmx_bus_matrix.sv
// Bus matrix: three initiators, ten target ports, access table and arbitration
`timescale 1ns/10ps

// Operation
// R1: Three initiators: slave port 0 dma, 1 usb device, 2 processor core.
// R2: Same-port requests in one cycle go to the lowest slave port number.
// R3: Access to a faulting range for that initiator is refused as a fault.
// R4: Single-chip map: flash on M0, RAM0 on M1, RAM1 on M2, faults between.
// R5: Single-boot map: boot mirror on M3 core only, flash mirror on M0.
// R6: Peripherals: core all, dma selected timers/serial/i2c/flash iface, usb only i2c.
// R7: Peripheral ranges route to ports M4 through M9.
// R8: Always-on block takes byte transfers only and no bit-band alias.
// R9: Bit-band aliases cover SRAM and SFR, except the always-on block.
// R10: ROM in code region, RAM in SRAM region, registers in peripheral region.
// R11: Reserved and vendor regions must not be accessed; their answer is undefined.
// R12: The core interrupt controller takes 32 interrupt request lines.
// R13: Requests to different ports proceed in the same cycle independently.
// R14: Boot mode is sampled once after reset and then held.
module bmx_bus_matrix (
    // Clock and reset
    input  wire logic                                        i_clk,
    input  wire logic                                        i_rstn,
    // Boot strap pin
    input  wire logic                                        i_boot_single,
    output logic                                             o_boot_single,
    output logic                                             o_mode_ready,
    // Initiator side
    input  wire logic [bmx_pkg::NUM_INIT-1:0]                i_req,
    input  wire logic [bmx_pkg::NUM_INIT-1:0][31:0]          i_addr,
    input  wire logic [bmx_pkg::NUM_INIT-1:0]                i_write,
    input  wire logic [bmx_pkg::NUM_INIT-1:0][1:0]           i_size,
    input  wire logic [bmx_pkg::NUM_INIT-1:0][31:0]          i_wdata,
    output logic      [bmx_pkg::NUM_INIT-1:0]                o_ack,
    output logic      [bmx_pkg::NUM_INIT-1:0]                o_fault,
    output logic      [bmx_pkg::NUM_INIT-1:0][31:0]          o_rdata,
    // Target side
    output logic      [bmx_pkg::NUM_PORT-1:0]                o_mp_req,
    output logic      [bmx_pkg::NUM_PORT-1:0][31:0]          o_mp_addr,
    output logic      [bmx_pkg::NUM_PORT-1:0]                o_mp_write,
    output logic      [bmx_pkg::NUM_PORT-1:0][1:0]           o_mp_size,
    output logic      [bmx_pkg::NUM_PORT-1:0][31:0]          o_mp_wdata,
    output logic      [bmx_pkg::NUM_PORT-1:0]                o_mp_bitband,
    output logic      [bmx_pkg::NUM_PORT-1:0][2:0]           o_mp_bit,
    output logic      [bmx_pkg::NUM_PORT-1:0][1:0]           o_mp_owner,
    input  wire logic [bmx_pkg::NUM_PORT-1:0][31:0]          i_mp_rdata,
    // Interrupt lines
    input  wire logic [bmx_pkg::NUM_IRQ-1:0]                 i_irq,
    output logic      [bmx_pkg::NUM_IRQ-1:0]                 o_core_irq
);
    import bmx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [SYNC_STAGES-1:0]            boot_sync;
    logic [SYNC_STAGES-1:0]            sync_fill;
    logic [NUM_INIT-1:0][3:0]          dport;
    logic [NUM_INIT-1:0]               dfault;
    logic [NUM_INIT-1:0][31:0]         dtaddr;
    logic [NUM_INIT-1:0]               dbitband;
    logic [NUM_INIT-1:0][2:0]          dbit;
    logic [NUM_INIT-1:0]               pending;
    logic [NUM_INIT-1:0][3:0]          pend_port;
    logic [NUM_INIT-1:0]               blocked;
    logic [NUM_INIT-1:0]               live;
    logic [NUM_INIT-1:0]               cand;
    logic [NUM_INIT-1:0]               granted;
    logic [NUM_PORT-1:0]               win_valid;
    logic [NUM_PORT-1:0][1:0]          win_idx;

    ////////////////////////////////////////////////////////////////////////////
    // Boot mode capture

    // Strap is asynchronous to i_clk, so two stages before the capture
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            boot_sync <= '0;
            sync_fill <= '0;
        end else begin
            boot_sync <= {boot_sync[SYNC_STAGES-2:0], i_boot_single};
            sync_fill <= {sync_fill[SYNC_STAGES-2:0], 1'b1};
        end
    end

    // Captured once; later strap changes cannot reshape the map
    // Waits for the strap to cross both stages, else the reset value of the chain is taken
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_mode_ready  <= 1'b0;
            o_boot_single <= 1'b0;
        end else if (!o_mode_ready && sync_fill[SYNC_STAGES-1]) begin
            o_mode_ready  <= 1'b1;                                                  // R14
            o_boot_single <= boot_sync[SYNC_STAGES-1];                              // R14
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode, one decoder per initiator

    for (genvar gi = 0; gi < NUM_INIT; gi++) begin : g_dec
        bmx_decode u_decode (
            .i_addr        (i_addr[gi]),
            .i_size        (i_size[gi]),
            .i_init        (2'(gi)),                                               // R1
            .i_boot_single (o_boot_single),
            .o_port        (dport[gi]),
            .o_fault       (dfault[gi]),
            .o_taddr       (dtaddr[gi]),
            .o_bitband     (dbitband[gi]),
            .o_bit         (dbit[gi])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration

    // An initiator is ignored while its transfer or answer is outstanding
    assign blocked = pending | o_ack | o_fault;
    assign live    = i_req & ~blocked & {NUM_INIT{o_mode_ready}};
    assign cand    = live & ~dfault;

    // Each port arbitrates on its own, so disjoint targets never wait
    always_comb begin
        for (int m = 0; m < NUM_PORT; m++) begin
            win_valid[m] = 1'b0;
            win_idx[m]   = 2'h0;
            for (int i = NUM_INIT - 1; i >= 0; i--) begin
                if (cand[i] && (dport[i] == 4'(m))) begin                          // R13
                    win_valid[m] = 1'b1;
                    win_idx[m]   = 2'(i);                                          // R2
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_INIT; i++) begin
            granted[i] = cand[i] && (win_idx[dport[i]] == 2'(i));                  // R2
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Target port registers

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_mp_req     <= '0;
            o_mp_addr    <= '0;
            o_mp_write   <= '0;
            o_mp_size    <= '0;
            o_mp_wdata   <= '0;
            o_mp_bitband <= '0;
            o_mp_bit     <= '0;
            o_mp_owner   <= '0;
        end else begin
            for (int m = 0; m < NUM_PORT; m++) begin
                o_mp_req[m] <= win_valid[m];                                       // R13
                if (win_valid[m]) begin
                    o_mp_addr[m]    <= dtaddr[win_idx[m]];                         // R7
                    o_mp_write[m]   <= i_write[win_idx[m]];
                    o_mp_size[m]    <= i_size[win_idx[m]];
                    o_mp_wdata[m]   <= i_wdata[win_idx[m]];
                    o_mp_bitband[m] <= dbitband[win_idx[m]];                       // R9
                    o_mp_bit[m]     <= dbit[win_idx[m]];
                    o_mp_owner[m]   <= win_idx[m];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outstanding transfer tracking

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pending   <= '0;
            pend_port <= '0;
        end else begin
            for (int i = 0; i < NUM_INIT; i++) begin
                if (granted[i]) begin
                    pending[i]   <= 1'b1;
                    pend_port[i] <= dport[i];
                end else if (pending[i]) begin
                    pending[i]   <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Initiator answers

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ack   <= '0;
            o_fault <= '0;
            o_rdata <= '0;
        end else begin
            for (int i = 0; i < NUM_INIT; i++) begin
                o_ack[i]   <= pending[i];
                o_fault[i] <= live[i] && dfault[i];                                // R3
                if (pending[i]) begin
                    o_rdata[i] <= i_mp_rdata[pend_port[i]];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt lines to the core

    // Peripherals share i_clk, so one register stage only
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_core_irq <= '0;
        end else begin
            o_core_irq <= i_irq;                                                   // R12
        end
    end

endmodule // bmx_bus_matrix

// file: core/bmx_decode.sv
// Address decoder for one initiator: bit-band translation, map lookup, fault check
`timescale 1ns/10ps

module bmx_decode (
    // Request
    input  wire logic [31:0] i_addr,
    input  wire logic [1:0]  i_size,
    input  wire logic [1:0]  i_init,
    input  wire logic        i_boot_single,
    // Decode result
    output logic      [3:0]  o_port,
    output logic             o_fault,
    output logic      [31:0] o_taddr,
    output logic             o_bitband,
    output logic      [2:0]  o_bit
);
    import bmx_pkg::*;

    always_comb begin
        bmx_entry_t hit;
        logic       in_ao;
        logic       is_sram_bb;
        logic       mode_ok;
        hit        = '{32'h0000_0000, PORT_NONE, ALLOW_NONE, MODE_BOTH};
        in_ao      = 1'b0;
        mode_ok    = 1'b0;
        is_sram_bb = (i_addr[31:25] == BB_SRAM_TAG);
        o_bitband  = is_sram_bb || (i_addr[31:25] == BB_PERI_TAG);                         // R9
        o_bit      = i_addr[4:2];
        o_taddr    = i_addr;
        if (o_bitband) begin
            o_taddr = (is_sram_bb ? BB_SRAM_BASE : BB_PERI_BASE) | {12'h000, i_addr[24:5]}; // R9
        end
        for (int k = 0; k < MAP_LEN; k++) begin
            mode_ok = i_boot_single ? BMX_MAP[k].modes[1] : BMX_MAP[k].modes[0];
            if (mode_ok && (BMX_MAP[k].start <= o_taddr)) begin
                hit = BMX_MAP[k];                                                      // R4 R5 R7 R10
            end
        end
        in_ao   = (o_taddr >= AO_BASE) && (o_taddr < AO_END);
        // Byte-only, no alias in the always-on block: refused rather than corrupted
        o_fault = !hit.allow[i_init] || (hit.port == PORT_NONE)                          // R3 R6
                  || (in_ao && (o_bitband || (i_size != SIZE_BYTE)));                   // R8 R9
        o_port  = o_fault ? PORT_NONE : hit.port;
    end

endmodule // bmx_decode

// file: core/bmx_pkg.sv
// Constants, types and the address map shared by the bus matrix files
package bmx_pkg;

    localparam int NUM_INIT = 3;
    localparam int NUM_PORT = 10;
    localparam int NUM_IRQ  = 32;
    localparam int MAP_LEN  = 40;

    // Initiator numbers, equal to the slave port number
    localparam logic [1:0] INIT_DMA  = 2'h0;
    localparam logic [1:0] INIT_USB  = 2'h1;
    localparam logic [1:0] INIT_CORE = 2'h2;

    localparam logic [3:0] PORT_NONE = 4'hf;

    // Transfer size codes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // Allow masks, one bit per initiator
    localparam logic [2:0] ALLOW_NONE = 3'h0;
    localparam logic [2:0] ALLOW_DMA  = 3'h1;
    localparam logic [2:0] ALLOW_ALL  = 3'h7;
    localparam logic [2:0] ALLOW_CORE = 3'h4;
    localparam logic [2:0] ALLOW_DC   = 3'h5;

    // Boot mode masks of a map entry
    localparam logic [1:0] MODE_CHIP = 2'h1;
    localparam logic [1:0] MODE_BOOT = 2'h2;
    localparam logic [1:0] MODE_BOTH = 2'h3;

    // Bit-band alias windows and their targets
    localparam logic [6:0]  BB_SRAM_TAG  = 7'h11;
    localparam logic [6:0]  BB_PERI_TAG  = 7'h21;
    localparam logic [31:0] BB_SRAM_BASE = 32'h2000_0000;
    localparam logic [31:0] BB_PERI_BASE = 32'h4000_0000;

    // Always-on register block window
    localparam logic [31:0] AO_BASE = 32'h4003_8000;
    localparam logic [31:0] AO_END  = 32'h4003_8c00;

    // Boot strap synchroniser depth
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic [31:0] start;
        logic [3:0]  port;
        logic [2:0]  allow;
        logic [1:0]  modes;
    } bmx_entry_t;

    // Sorted by start; the last entry of the current boot mode at or below an address wins
    localparam bmx_entry_t BMX_MAP [MAP_LEN] = '{
        '{32'h0000_0000, 4'h0,      ALLOW_ALL,  MODE_CHIP},
        '{32'h0000_0000, 4'h3,      ALLOW_CORE, MODE_BOOT},
        '{32'h0000_1000, PORT_NONE, ALLOW_NONE, MODE_BOOT},
        '{32'h0002_0000, PORT_NONE, ALLOW_NONE, MODE_CHIP},
        '{32'h2000_0000, 4'h1,      ALLOW_ALL,  MODE_BOTH},
        '{32'h2000_2000, 4'h2,      ALLOW_ALL,  MODE_BOTH},
        '{32'h2400_0000, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'h3f80_0000, 4'h0,      ALLOW_DC,   MODE_BOOT},
        '{32'h3f82_0000, PORT_NONE, ALLOW_NONE, MODE_BOOT},
        '{32'h4000_0000, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'h4000_8000, 4'h8,      ALLOW_CORE, MODE_BOTH},
        '{32'h4000_9000, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'h4003_8000, 4'h9,      ALLOW_CORE, MODE_BOTH},
        '{32'h4003_8c00, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'h4004_c000, 4'h4,      ALLOW_CORE, MODE_BOTH},
        '{32'h4005_8000, 4'h4,      ALLOW_DC,   MODE_BOTH},
        '{32'h4008_d000, 4'h5,      ALLOW_DC,   MODE_BOTH},
        '{32'h4009_8000, 4'h5,      ALLOW_DC,   MODE_BOTH},
        '{32'h4009_9000, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'h400a_0000, 4'h4,      ALLOW_ALL,  MODE_BOTH},
        '{32'h400a_1000, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'h400c_0000, 4'h6,      ALLOW_CORE, MODE_BOTH},
        '{32'h400c_0800, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'h400c_4000, 4'h6,      ALLOW_CORE, MODE_BOTH},
        '{32'h400c_4800, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'h400e_1000, 4'h7,      ALLOW_CORE, MODE_BOTH},
        '{32'h400e_1500, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'h400f_2000, 4'h7,      ALLOW_CORE, MODE_BOTH},
        '{32'h400f_2100, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'h400f_3000, 4'h7,      ALLOW_CORE, MODE_BOTH},
        '{32'h400f_3600, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'h400f_4000, 4'h7,      ALLOW_CORE, MODE_BOTH},
        '{32'h400f_4e00, 4'h7,      ALLOW_DC,   MODE_BOTH},
        '{32'h400f_5000, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'h400f_c000, 4'h7,      ALLOW_CORE, MODE_BOTH},
        '{32'h400f_c100, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'h41ff_ff00, 4'h7,      ALLOW_CORE, MODE_BOTH},
        '{32'h4400_0000, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'he000_0000, PORT_NONE, ALLOW_NONE, MODE_BOTH},
        '{32'hffff_ffff, PORT_NONE, ALLOW_NONE, MODE_BOTH}
    };

endpackage

// file: tb/bmx_checker.sv
// Port-level assertions for the bus matrix
`timescale 1ns/10ps

module bmx_checker (
    input wire logic                                i_clk,
    input wire logic                                i_rstn,
    input wire logic [bmx_pkg::NUM_INIT-1:0]        i_req,
    input wire logic [bmx_pkg::NUM_INIT-1:0][31:0]  i_addr,
    input wire logic [bmx_pkg::NUM_IRQ-1:0]         i_irq,
    input wire logic                                o_mode_ready,
    input wire logic                                o_boot_single,
    input wire logic [bmx_pkg::NUM_INIT-1:0]        o_ack,
    input wire logic [bmx_pkg::NUM_INIT-1:0]        o_fault,
    input wire logic [bmx_pkg::NUM_PORT-1:0]        o_mp_req,
    input wire logic [bmx_pkg::NUM_PORT-1:0][31:0]  o_mp_addr,
    input wire logic [bmx_pkg::NUM_PORT-1:0][1:0]   o_mp_size,
    input wire logic [bmx_pkg::NUM_PORT-1:0]        o_mp_bitband,
    input wire logic [bmx_pkg::NUM_PORT-1:0][1:0]   o_mp_owner,
    input wire logic [bmx_pkg::NUM_IRQ-1:0]         o_core_irq
);
    import bmx_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    mode_hold_a: assert property (o_mode_ready && $past(o_mode_ready) |-> $stable(o_boot_single))
        else $error("boot mode changed while running");
    irq_delay_a: assert property ($past(i_rstn) |-> o_core_irq == $past(i_irq))
        else $error("interrupt lines not passed after one cycle");
    high_fault_a: assert property (i_req[2] && i_addr[2] >= 32'h4400_0000 && o_mode_ready && !o_ack[2]
        && !o_fault[2] |-> ##[1:2] o_fault[2]) else $error("high address not faulted");
    boot_rom_a: assert property (o_mp_req[3] |-> o_mp_owner[3] == INIT_CORE && o_boot_single)
        else $error("boot mirror reached wrongly");
    flash_range_a: assert property (o_mp_req[0] |-> (o_boot_single ? (o_mp_addr[0] >= 32'h3f80_0000
        && o_mp_addr[0] < 32'h3f82_0000) : o_mp_addr[0] < 32'h0002_0000)) else $error("flash port out of range");
    ao_byte_a: assert property (o_mp_req[9] |-> o_mp_size[9] == SIZE_BYTE && !o_mp_bitband[9]
        && o_mp_owner[9] == INIT_CORE) else $error("bad always-on access passed");
    peri_owner_a: assert property ((!o_mp_req[5] || o_mp_owner[5] != INIT_USB)
        && (!o_mp_req[6] || o_mp_owner[6] == INIT_CORE)) else $error("peripheral port owner not allowed");
    grant_ack_a: assert property (o_mp_req[1] |=> o_ack[$past(o_mp_owner[1])])
        else $error("granted transfer not acknowledged");
    arb_order_a: assert property ($rose(i_req[0]) && $rose(i_req[2]) && i_addr[0] == 32'h400a_0000
        && i_addr[2] == 32'h400a_0000 && o_mode_ready |=> o_mp_req[4] && o_mp_owner[4] == INIT_DMA
        ##1 o_mp_req[4] && o_mp_owner[4] == INIT_CORE) else $error("lowest slave port not first");
endmodule // bmx_checker

bind bmx_bus_matrix bmx_checker u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_addr(i_addr),
    .i_irq(i_irq), .o_mode_ready(o_mode_ready), .o_boot_single(o_boot_single), .o_ack(o_ack),
    .o_fault(o_fault), .o_mp_req(o_mp_req), .o_mp_addr(o_mp_addr), .o_mp_size(o_mp_size),
    .o_mp_bitband(o_mp_bitband), .o_mp_owner(o_mp_owner), .o_core_irq(o_core_irq));

// file: tb/bmx_target_model.sv
// Target-side model: answers every port in the same cycle with a port-stamped pattern
`timescale 1ns/10ps

module bmx_target_model (
    // Port requests
    input  wire logic [bmx_pkg::NUM_PORT-1:0]       i_req,
    input  wire logic [bmx_pkg::NUM_PORT-1:0][31:0] i_addr,
    // Read answers
    output logic      [bmx_pkg::NUM_PORT-1:0][31:0] o_rdata
);
    import bmx_pkg::*;

    // Idle ports show the inverse so a late sample cannot pass by luck
    always_comb begin
        for (int m = 0; m < NUM_PORT; m++) begin
            o_rdata[m] = {m[3:0], i_addr[m][27:0]} ^ {32{!i_req[m]}};
        end
    end
endmodule // bmx_target_model

// file: tb/tb_bmx_bus_matrix.sv
// Self-checking bench for the bus matrix
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb_bmx_bus_matrix;
    import bmx_pkg::*;
    logic                          i_clk, i_rstn, i_boot_single, o_boot_single, o_mode_ready;
    logic [NUM_INIT-1:0]           i_req, i_write, o_ack, o_fault;
    logic [NUM_INIT-1:0][31:0]     i_addr, i_wdata, o_rdata;
    logic [NUM_INIT-1:0][1:0]      i_size;
    logic [NUM_PORT-1:0]           o_mp_req, o_mp_write, o_mp_bitband;
    logic [NUM_PORT-1:0][31:0]     o_mp_addr, o_mp_wdata, i_mp_rdata;
    logic [NUM_PORT-1:0][1:0]      o_mp_size, o_mp_owner;
    logic [NUM_PORT-1:0][2:0]      o_mp_bit;
    logic [NUM_IRQ-1:0]            i_irq, o_core_irq;
    int                            mismatches = 0;
    int                            n_tests = 0;

    bmx_bus_matrix dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_boot_single(i_boot_single),
        .o_boot_single(o_boot_single), .o_mode_ready(o_mode_ready), .i_req(i_req), .i_addr(i_addr),
        .i_write(i_write), .i_size(i_size), .i_wdata(i_wdata), .o_ack(o_ack), .o_fault(o_fault),
        .o_rdata(o_rdata), .o_mp_req(o_mp_req), .o_mp_addr(o_mp_addr), .o_mp_write(o_mp_write),
        .o_mp_size(o_mp_size), .o_mp_wdata(o_mp_wdata), .o_mp_bitband(o_mp_bitband), .o_mp_bit(o_mp_bit),
        .o_mp_owner(o_mp_owner), .i_mp_rdata(i_mp_rdata), .i_irq(i_irq), .o_core_irq(o_core_irq));
    bmx_target_model u_tgt (.i_req(o_mp_req), .i_addr(o_mp_addr), .o_rdata(i_mp_rdata));

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic do_reset(input logic strap);
        @(posedge i_clk);
        i_rstn <= 1'b0;
        i_boot_single <= strap;
        i_req <= '0;
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'b1;
        // Mode is captured on the third edge after release
        repeat (3) @(posedge i_clk);
        #1;
        `CHK("mode_ready", 1'b1, o_mode_ready)
        `CHK("boot_single", strap, o_boot_single)
    endtask

    // Fault expected when p is PORT_NONE; request is dropped on the edge its answer is launched
    task automatic do_xfer(input logic [1:0] i, input logic [31:0] a, input logic [1:0] sz,
                           input logic wr, input logic [3:0] p, input logic [31:0] ta);
        int n;
        n = 0;
        @(posedge i_clk);
        i_req[i] <= 1'b1;
        i_addr[i] <= a;
        i_size[i] <= sz;
        i_write[i] <= wr;
        i_wdata[i] <= ~a;
        if (p == PORT_NONE) begin
            @(posedge i_clk);
            i_req[i] <= 1'b0;
            #1;
            `CHK("fault", 1'b1, o_fault[i])
        end else begin
            do begin
                @(posedge i_clk);
                #1;
                n++;
            end while (n < 20 && !(o_mp_req[p] === 1'b1 && o_mp_owner[p] === i));
            `CHK("port_req", 1'b1, o_mp_req[p])
            `CHK("port_addr", ta, o_mp_addr[p])
            `CHK("port_write", wr, o_mp_write[p])
            if (wr) `CHK("port_wdata", ~a, o_mp_wdata[p])
            @(posedge i_clk);
            i_req[i] <= 1'b0;
            #1;
            `CHK("ack", 1'b1, o_ack[i])
            if (!wr) `CHK("rdata", {p, ta[27:0]}, o_rdata[i])
        end
    endtask

    // Table row: initiator in [37:36], port in [35:32], address in [31:0]
    task automatic do_row(input logic [39:0] r, input logic [1:0] sz, input logic wr);
        do_xfer(r[37:36], r[31:0], sz, wr, r[35:32], r[31:0]);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Only mapped or fault-marked ranges; reserved holes are addressed only to check that they fault
    localparam logic [39:0] CHIP_T [20] = '{
        {4'h2, 4'h0, 32'h0000_0000}, {4'h1, 4'h0, 32'h0001_fffc}, {4'h0, 4'hf, 32'h0002_0000},
        {4'h1, 4'h1, 32'h2000_0000}, {4'h0, 4'h2, 32'h2000_2000}, {4'h2, 4'hf, 32'h2400_0000},
        {4'h1, 4'hf, 32'h4000_0000}, {4'h0, 4'h4, 32'h4005_8000}, {4'h1, 4'hf, 32'h4005_8000},
        {4'h1, 4'h4, 32'h400a_0000}, {4'h0, 4'hf, 32'h400a_1000}, {4'h0, 4'h7, 32'h400f_4e00},
        {4'h0, 4'hf, 32'h400f_4000}, {4'h2, 4'h6, 32'h400c_4000}, {4'h2, 4'h8, 32'h4000_8000},
        {4'h0, 4'h5, 32'h4009_8000}, {4'h2, 4'h7, 32'h41ff_ff00}, {4'h2, 4'h9, 32'h4003_8000},
        {4'h2, 4'hf, 32'h4400_0000}, {4'h2, 4'hf, 32'h3f80_0000}};
    localparam logic [39:0] BOOT_T [9] = '{
        {4'h2, 4'h3, 32'h0000_0000}, {4'h0, 4'hf, 32'h0000_0000}, {4'h1, 4'hf, 32'h0000_0ffc},
        {4'h2, 4'hf, 32'h0000_1000}, {4'h0, 4'h0, 32'h3f80_0000}, {4'h1, 4'hf, 32'h3f80_0000},
        {4'h2, 4'h0, 32'h3f81_fffc}, {4'h2, 4'hf, 32'h3f82_0000}, {4'h1, 4'h1, 32'h2000_0000}};

    task automatic t_chip();
        foreach (CHIP_T[k]) do_row(CHIP_T[k], SIZE_BYTE, k[0]);
        do_xfer(INIT_CORE, 32'h4003_8000, SIZE_WORD, 1'b0, PORT_NONE, '0);
        do_xfer(INIT_CORE, 32'h4270_0000, SIZE_BYTE, 1'b0, PORT_NONE, '0);
        do_xfer(INIT_CORE, 32'h2200_020c, SIZE_BYTE, 1'b1, 4'h1, 32'h2000_0010);
        `CHK("bitband", 4'hb, {o_mp_bitband[1], o_mp_bit[1]})
        do_xfer(INIT_USB, 32'h4340_0004, SIZE_BYTE, 1'b0, 4'h4, 32'h400a_0000);
        `CHK("bit_no", 3'h1, o_mp_bit[4])
        $display("test chip_map done");
    endtask

    task automatic t_arb();
        @(posedge i_clk);
        i_req <= 3'h5;
        i_addr <= {32'h400a_0000, 32'h0, 32'h400a_0000};
        i_write <= '0;
        @(posedge i_clk);
        #1;
        `CHK("first_owner", {1'b1, INIT_DMA}, {o_mp_req[4], o_mp_owner[4]})
        @(posedge i_clk);
        i_req[0] <= 1'b0;
        #1;
        `CHK("second_owner", {1'b1, INIT_CORE}, {o_mp_req[4], o_mp_owner[4]})
        @(posedge i_clk);
        i_req[2] <= 1'b0;
        i_addr <= {32'h0000_0000, 32'h2000_2000, 32'h2000_0000};
        @(posedge i_clk);
        i_req <= 3'h7;
        @(posedge i_clk);
        #1;
        `CHK("parallel_req", 3'h7, o_mp_req[2:0])
        @(posedge i_clk);
        i_req <= '0;
        #1;
        `CHK("parallel_ack", 3'h7, o_ack)
        $display("test arbitration done");
    endtask

    task automatic t_irq();
        @(posedge i_clk);
        i_irq <= 32'ha5c3_0f81;
        @(posedge i_clk);
        #1;
        `CHK("core_irq", 32'ha5c3_0f81, o_core_irq)
        $display("test irq done");
    endtask

    task automatic t_boot();
        do_reset(1'b1);
        foreach (BOOT_T[k]) do_row(BOOT_T[k], SIZE_WORD, 1'b0);
        @(posedge i_clk);
        i_boot_single <= 1'b0;
        repeat (5) @(posedge i_clk);
        #1;
        `CHK("mode_held", 1'b1, o_boot_single)
        do_xfer(INIT_CORE, 32'h0000_0000, SIZE_WORD, 1'b0, 4'h3, 32'h0000_0000);
        $display("test boot_map done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    initial begin
        repeat (5000) @(posedge i_clk);
        mismatches++;
        print_verdict();
    end

    initial begin
        i_rstn = 1'b0;
        i_boot_single = 1'b0;
        i_req = '0;
        i_addr = '0;
        i_write = '0;
        i_size = '0;
        i_wdata = '0;
        i_irq = '0;
        do_reset(1'b0);
        t_chip();
        t_arb();
        t_irq();
        t_boot();
        print_verdict();
    end
endmodule // tb_bmx_bus_matrix
